// ===== logic/dpc_top.sv
// Shared data pin mux, port A and DMA handshake configuration logic
//
// Overview of operation
// - Function select 0 routes the eight shared pins to port A, bit per pin.
// - Port A input mode: reading port A returns live pin levels, never written data.
// - Port A output mode: read value is undefined and must not be relied on.
// - Direction bit b2: 0 all inputs, 1 all outputs; only in port mode.
// - Function select 1 gives pins to split bus; CPU DMA FIFO accesses ignored.
// - Byte order b8 for both FIFO ports: 0 upper byte odd, 1 reversed.
// - Bit 14 sets request polarity, bit 12 enables driving the request output.
// - Bit 13 picks cycle-steal (0) or burst (1) request timing.
// - Bit 8 picks CPU-bus pins or acknowledge pin; bit 10 its polarity.
// - With bit 8 set, bit 9 picks separate write/read strobes (0) or the single DMA strobe.
// - End pin: bit 4 enable, bit 6 polarity, bit 5 transaction or buffer mode.
// - Bit 2 picks high-speed drive (0) or normal drive (1) of data and end pins.
// - Both configuration registers clear on hardware reset only.
// - Cycle-steal: request per transfer, negated on each acknowledge.
// - Burst: request held through transfer, negated when all data is done.
// - OUT end pin: count done or short packet, or full buffer in buffer mode.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module dpc_top
  import dpc_pkg::*;
(
  input  wire logic                  mclk,                // System clock, 100 MHz
  input  wire logic                  rst_n,               // Asynchronous hardware reset
  input  wire logic [7:0]            reg_addr,            // Register byte address
  input  wire logic [15:0]           reg_wdata,           // Register write data
  input  wire logic                  reg_wr,              // Write strobe, one cycle
  input  wire logic                  reg_rd,              // Read strobe, one cycle
  output logic      [15:0]           reg_rdata,           // Read data, cycle after strobe
  input  wire logic [7:0]            split_data_pins_i,   // Shared pin levels
  output logic      [7:0]            split_data_pins_o,   // Shared pin drive value
  output logic                       split_data_pins_oe,  // Shared pin drive enable
  input  wire dpc_pkg::dpc_hs_pins_t hs_pins_i,           // Handshake pins, asynchronous
  input  wire logic                  cpu_dma_select,      // CPU-bus handshake decode
  output logic                       dma_request_o,       // Request pin level
  output logic                       dma_request_oe,      // Request pin enable
  output logic                       dma_transfer_end_o,  // End pin level
  output logic                       dma_transfer_end_oe, // End pin enable
  input  wire logic                  fifo_data_ready,     // FIFO has data work for DMA
  input  wire logic                  fifo_all_done,       // All data of the job moved
  input  wire logic                  pipe_dir_out,        // Current pipe is OUT
  input  wire logic                  packet_count_done,   // Packet count reached
  input  wire logic                  short_packet_done,   // Short packet moved
  input  wire logic                  buffer_full_done,    // Full pipe buffer moved
  input  wire logic [7:0]            fifo_tx_byte,        // Byte to drive on split bus
  output logic                       dma_xfer_pulse,      // One split-bus transfer done
  output logic      [7:0]            dma_rx_byte,         // Byte taken from split bus
  input  wire logic [15:0]           fifo_cpu_rd_data,    // FIFO word, lower lane first
  output logic                       cpu_fifo_wr,         // CPU write to DMA FIFO port
  output logic                       cpu_fifo_rd,         // CPU read of DMA FIFO port
  output logic      [15:0]           cpu_fifo_wdata       // Lane-ordered write word
);
  import dpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [DPC_SYNC_W-1:0] sync1_q;
  logic [DPC_SYNC_W-1:0] sync2_q;
  logic [7:0]            pin_lvl;
  dpc_hs_pins_t          hs_lvl;

  // Two flops; only the second stage is read by any logic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {split_data_pins_i, hs_pins_i};
      sync2_q <= sync1_q;
    end
  end

  assign pin_lvl = sync2_q[DPC_SYNC_W-1:4];
  assign hs_lvl  = dpc_hs_pins_t'(sync2_q[3:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  dpc_mode_cfg_t mode_q, mode_d;
  dpc_hs_cfg_t   hs_q, hs_d;
  logic [7:0]    porta_q, porta_d;
  logic [15:0]   rdata_q, rdata_d;
  logic          fwr_q, fwr_d;
  logic          frd_q, frd_d;
  logic [15:0]   fwdata_q, fwdata_d;
  logic          split_mode;

  assign split_mode = mode_q.shared_pin_function_select;

  // Lane order: the FIFO side always sees the lower lane as the even byte
  function automatic logic [15:0] lane_order(input logic [15:0] w, input logic big);
    lane_order = big ? {w[7:0], w[15:8]} : w;
  endfunction

  // Decode writes and reads; reserved bits are masked off at write time
  always_comb begin
    mode_d   = mode_q;
    hs_d     = hs_q;
    porta_d  = porta_q;
    rdata_d  = 16'h0000;
    fwr_d    = 1'b0;
    frd_d    = 1'b0;
    fwdata_d = fwdata_q;
    if (reg_wr) begin
      case (reg_addr)
        DPC_MODE_OFS:  mode_d = dpc_mode_cfg_t'(reg_wdata & DPC_MODE_MASK);
        DPC_HS_OFS:    hs_d = dpc_hs_cfg_t'(reg_wdata & DPC_HS_MASK);
        // Output latch written even in input mode, so software can preload it
        DPC_PORTA_OFS: porta_d = reg_wdata[7:0];
        DPC_FIFO_OFS: begin
          if (!split_mode) begin
            fwr_d    = 1'b1;
            fwdata_d = lane_order(reg_wdata, mode_q.big_endian);
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        DPC_MODE_OFS:  rdata_d = mode_q;
        DPC_HS_OFS:    rdata_d = hs_q;
        // Always the pin levels; in output mode this is not a defined value
        DPC_PORTA_OFS: rdata_d = {8'h00, pin_lvl};
        DPC_FIFO_OFS: begin
          if (!split_mode) begin
            frd_d   = 1'b1;
            rdata_d = lane_order(fifo_cpu_rd_data, mode_q.big_endian);
          end
        end
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // Only the hardware reset clears configuration
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q   <= dpc_mode_cfg_t'(DPC_CFG_RST);
      hs_q     <= dpc_hs_cfg_t'(DPC_CFG_RST);
      porta_q  <= DPC_PORTA_RST;
      rdata_q  <= 16'h0000;
      fwr_q    <= 1'b0;
      frd_q    <= 1'b0;
      fwdata_q <= 16'h0000;
    end else begin
      mode_q   <= mode_d;
      hs_q     <= hs_d;
      porta_q  <= porta_d;
      rdata_q  <= rdata_d;
      fwr_q    <= fwr_d;
      frd_q    <= frd_d;
      fwdata_q <= fwdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake decode

  logic ack_act;
  logic strb_n;
  logic strb_act;
  logic split_dma;

  // Split-bus DMA only when the acknowledge pin is the handshake
  assign split_dma = split_mode & hs_q.handshake_source_select;
  // Pin compared against its active level, else the CPU-bus decode
  assign ack_act = hs_q.handshake_source_select ?
                   (hs_lvl.dma_acknowledge == hs_q.acknowledge_polarity) :
                   cpu_dma_select;
  // Single DMA strobe only counts with the acknowledge pin selected
  assign strb_n = (hs_q.handshake_source_select & hs_q.strobe_mode_select) ?
                  hs_lvl.dma_strobe_n :
                  (hs_lvl.write_strobe_n & hs_lvl.read_strobe_n);
  assign strb_act = ~strb_n & ack_act;

  ////////////////////////////////////////////////////////////////////////////
  // Request sequencer

  dpc_req_st_t st_q, st_d;
  logic        strb_prev_q, strb_prev_d;

  // Cycle-steal drops the request on every acknowledge; burst holds it to the end
  always_comb begin
    st_d        = st_q;
    strb_prev_d = strb_act;
    case (st_q)
      DPC_REQ_IDLE: begin
        if (fifo_data_ready && !fifo_all_done) begin
          st_d = DPC_REQ_ON;
        end
      end
      DPC_REQ_ON: begin
        if (hs_q.burst_mode) begin
          if (fifo_all_done) begin
            st_d = DPC_REQ_IDLE;
          end
        end else if (ack_act) begin
          st_d = DPC_REQ_RELEASE;
        end
      end
      // Wait for the acknowledge to go away so one ack ends one request
      DPC_REQ_RELEASE: begin
        if (!ack_act) begin
          st_d = DPC_REQ_IDLE;
        end
      end
      default: st_d = DPC_REQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= DPC_REQ_IDLE;
      strb_prev_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      strb_prev_q <= strb_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  logic       req_act;
  logic       end_act;
  logic       drv_win;
  logic       xfer_edge;
  logic [7:0] pin_o_d, pin_o_q;
  logic       pin_oe_d, pin_oe_q;
  logic       req_o_d, req_o_q;
  logic       req_oe_d, req_oe_q;
  logic       end_o_d, end_o_q;
  logic       end_oe_d, end_oe_q;
  logic       xfer_d, xfer_q;
  logic [7:0] rx_d, rx_q;

  assign req_act   = (st_q == DPC_REQ_ON);
  assign xfer_edge = strb_act & ~strb_prev_q;
  // End condition only has meaning for OUT pipes
  assign end_act = pipe_dir_out & (hs_q.end_buffer_mode ? buffer_full_done :
                   (packet_count_done | short_packet_done));
  // Normal drive only in the strobe window; high-speed drive all the time
  assign drv_win = hs_q.normal_drive_mode ? strb_act : 1'b1;

  always_comb begin
    // Port mode: direction bit drives all eight pins together
    if (!split_mode) begin
      pin_o_d  = porta_q;
      pin_oe_d = mode_q.port_a_direction;
    end else begin
      pin_o_d  = fifo_tx_byte;
      pin_oe_d = split_dma & pipe_dir_out & drv_win;
    end
    req_o_d  = hs_q.request_polarity ? req_act : ~req_act;
    req_oe_d = hs_q.request_output_enable;
    end_o_d  = hs_q.end_pin_polarity ? end_act : ~end_act;
    // Disabled end pin floats; IN pipes leave it as an input
    end_oe_d = hs_q.end_pin_enable & pipe_dir_out & drv_win;
    xfer_d   = split_dma & xfer_edge;
    rx_d     = (split_dma & xfer_edge & ~pipe_dir_out) ? pin_lvl : rx_q;
  end

  // Registered so every pin and pulse comes straight from a flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o_q  <= 8'h00;
      pin_oe_q <= 1'b0;
      req_o_q  <= 1'b0;
      req_oe_q <= 1'b0;
      end_o_q  <= 1'b0;
      end_oe_q <= 1'b0;
      xfer_q   <= 1'b0;
      rx_q     <= 8'h00;
    end else begin
      pin_o_q  <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      req_o_q  <= req_o_d;
      req_oe_q <= req_oe_d;
      end_o_q  <= end_o_d;
      end_oe_q <= end_oe_d;
      xfer_q   <= xfer_d;
      rx_q     <= rx_d;
    end
  end

  // Output wiring
  assign reg_rdata           = rdata_q;
  assign split_data_pins_o   = pin_o_q;
  assign split_data_pins_oe  = pin_oe_q;
  assign dma_request_o       = req_o_q;
  assign dma_request_oe      = req_oe_q;
  assign dma_transfer_end_o  = end_o_q;
  assign dma_transfer_end_oe = end_oe_q;
  assign dma_xfer_pulse      = xfer_q;
  assign dma_rx_byte         = rx_q;
  assign cpu_fifo_wr         = fwr_q;
  assign cpu_fifo_rd         = frd_q;
  assign cpu_fifo_wdata      = fwdata_q;

endmodule

// ===== logic/dpc_pkg.sv
// Package for the shared data pin and DMA handshake configuration block
package dpc_pkg;
  // Register offsets (byte addresses on the register port)
  localparam logic [7:0]  DPC_PORTA_OFS = 8'h08;
  localparam logic [7:0]  DPC_MODE_OFS  = 8'h0A;
  localparam logic [7:0]  DPC_HS_OFS    = 8'h0C;
  localparam logic [7:0]  DPC_FIFO_OFS  = 8'h18;
  // Writable bit masks; every other bit is reserved and reads zero
  localparam logic [15:0] DPC_MODE_MASK = 16'h0105;
  localparam logic [15:0] DPC_HS_MASK   = 16'h7774;
  localparam logic [15:0] DPC_CFG_RST   = 16'h0000;
  localparam logic [7:0]  DPC_PORTA_RST = 8'h00;
  localparam int          DPC_SYNC_W    = 12;

  // Data pin mode configuration layout
  typedef struct packed {
    logic [6:0] rsv_15_9;
    logic       big_endian;
    logic [4:0] rsv_7_3;
    logic       port_a_direction;
    logic       rsv_1;
    logic       shared_pin_function_select;
  } dpc_mode_cfg_t;

  // DMA handshake configuration layout
  typedef struct packed {
    logic       rsv_15;
    logic       request_polarity;
    logic       burst_mode;
    logic       request_output_enable;
    logic       rsv_11;
    logic       acknowledge_polarity;
    logic       strobe_mode_select;
    logic       handshake_source_select;
    logic       rsv_7;
    logic       end_pin_polarity;
    logic       end_buffer_mode;
    logic       end_pin_enable;
    logic       rsv_3;
    logic       normal_drive_mode;
    logic [1:0] rsv_1_0;
  } dpc_hs_cfg_t;

  // Handshake pins coming from the DMA controller side
  typedef struct packed {
    logic dma_acknowledge;
    logic dma_strobe_n;
    logic write_strobe_n;
    logic read_strobe_n;
  } dpc_hs_pins_t;

  // Request sequencer states
  typedef enum logic [1:0] {
    DPC_REQ_IDLE,
    DPC_REQ_ON,
    DPC_REQ_RELEASE
  } dpc_req_st_t;
endpackage

// ===== tb/dpc_top_sva.sv
// Concurrent checks on the shared pin and DMA handshake block ports
`timescale 1ns/10ps
module dpc_top_sva (
  input wire logic        mclk,               // Clock
  input wire logic        rst_n,              // Reset
  input wire logic [7:0]  reg_addr,           // Address
  input wire logic [15:0] reg_wdata,          // Write data
  input wire logic        reg_wr,             // Write strobe
  input wire logic        reg_rd,             // Read strobe
  input wire logic [15:0] reg_rdata,          // Read data
  input wire logic [7:0]  split_data_pins_i,  // Pin levels
  input wire logic [7:0]  split_data_pins_o,  // Pin drive
  input wire logic        split_data_pins_oe, // Pin enable
  input wire logic        dma_request_o,      // Request level
  input wire logic        dma_request_oe,     // Request enable
  input wire logic        fifo_all_done,      // Job done
  input wire logic        cpu_fifo_wr,        // FIFO write pulse
  input wire logic [15:0] cpu_fifo_wdata      // FIFO write word
);
  import dpc_pkg::*;
  logic [15:0] mode_q, mode_d, hs_q, hs_d;
  logic [7:0]  pa_q, pa_d;
  logic        act;
  ////////////////////////////////////////////////////////////
  // Shadow of what software wrote, masked as the block keeps it
  always_comb begin
    mode_d = mode_q;
    hs_d = hs_q;
    pa_d = pa_q;
    if (reg_wr && reg_addr == DPC_MODE_OFS) mode_d = reg_wdata & DPC_MODE_MASK;
    if (reg_wr && reg_addr == DPC_HS_OFS) hs_d = reg_wdata & DPC_HS_MASK;
    if (reg_wr && reg_addr == DPC_PORTA_OFS) pa_d = reg_wdata[7:0];
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= DPC_CFG_RST;
      hs_q <= DPC_CFG_RST;
      pa_q <= DPC_PORTA_RST;
    end else begin
      mode_q <= mode_d;
      hs_q <= hs_d;
      pa_q <= pa_d;
    end
  end
  // A polarity change makes the idle level look active for a cycle
  assign act = (dma_request_o == hs_q[14]);
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_mode_read: assert property (reg_rd && reg_addr == DPC_MODE_OFS |=> reg_rdata == mode_q)
    else $error("Mode register readback wrong");
  chk_hs_read: assert property (reg_rd && reg_addr == DPC_HS_OFS |=> reg_rdata == hs_q)
    else $error("Handshake register readback wrong");
  chk_port_drive: assert property (!mode_q[0] && $stable(mode_q) && $stable(pa_q)
    |-> split_data_pins_oe == mode_q[2] && (!mode_q[2] || split_data_pins_o == pa_q))
    else $error("Port A drive wrong");
  chk_port_input: assert property (reg_rd && reg_addr == DPC_PORTA_OFS && mode_q[2:0] == 3'h0
    && $stable(split_data_pins_i) && $past(split_data_pins_i, 3) == split_data_pins_i
    |=> reg_rdata == {8'h00, $past(split_data_pins_i)})
    else $error("Port A input readback wrong");
  chk_fifo_ignore: assert property (reg_wr && reg_addr == DPC_FIFO_OFS && mode_q[0] |=> !cpu_fifo_wr)
    else $error("FIFO port write taken in split mode");
  chk_byte_order: assert property (reg_wr && reg_addr == DPC_FIFO_OFS && !mode_q[0]
    |=> cpu_fifo_wr && cpu_fifo_wdata == ($past(mode_q[8])
    ? {$past(reg_wdata[7:0]), $past(reg_wdata[15:8])} : $past(reg_wdata)))
    else $error("FIFO port byte order wrong");
  chk_req_enable: assert property ($stable(hs_q) |-> dma_request_oe == hs_q[12])
    else $error("Request enable wrong");
  chk_burst_hold: assert property (hs_q[13] && act && !fifo_all_done && $stable(hs_q) |=> act)
    else $error("Burst request dropped early");
  chk_burst_drop: assert property (hs_q[13] && fifo_all_done |-> ##[1:4] !act)
    else $error("Burst request not dropped");
  cov_burst_end: cover property (hs_q[13] && act ##1 fifo_all_done);
  cov_big_end: cover property (reg_wr && reg_addr == DPC_FIFO_OFS && mode_q[8]);
  cov_port_out: cover property (split_data_pins_oe && !mode_q[0]);
endmodule
bind dpc_top dpc_top_sva dpc_top_sva_inst (.*);

// ===== tb/dpc_dma_model.sv
// Behavioural DMA controller answering the request on the handshake pins
`timescale 1ns/10ps
module dpc_dma_model (
  input wire logic        mclk,     // Clock
  input wire logic        rst_n,    // Reset
  input wire logic        req,      // Request pin level
  input wire logic        req_pol,  // Request active level
  input wire logic        ack_pol,  // Acknowledge active level
  input wire logic [3:0]  wait_cyc, // Answer delay, prompt or slow
  output dpc_pkg::dpc_hs_pins_t hs_pins   // Handshake pins
);
  import dpc_pkg::*;
  logic [4:0] cnt_q, cnt_d, w;
  logic       on;
  ////////////////////////////////////////////////////////////
  // One acknowledge window per request seen; burst simply repeats it
  assign w = {1'h0, wait_cyc};
  always_comb begin
    cnt_d = cnt_q;
    if (cnt_q != 5'h0 || req == req_pol) cnt_d = cnt_q + 5'h1;
    if (cnt_q == w + 5'h6) cnt_d = 5'h0;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 5'h0;
    else cnt_q <= cnt_d;
  end
  // Strobe low only inside the acknowledge, so each window is one transfer
  assign on = cnt_q > w && cnt_q <= w + 5'h4;
  assign hs_pins.dma_acknowledge = on ? ack_pol : !ack_pol;
  assign hs_pins.dma_strobe_n = !(cnt_q == w + 5'h2 || cnt_q == w + 5'h3);
  assign hs_pins.write_strobe_n = 1'h1; // Pulled up, unused strobes
  assign hs_pins.read_strobe_n = 1'h1;
endmodule

// ===== tb/tb_dpc_top.sv
// Self-checking bench for the shared pin and DMA handshake block
`timescale 1ns/10ps
module tb_dpc_top;
  import dpc_pkg::*;
  logic         mclk, rst_n, reg_wr, reg_rd, cpu_dma_select, fifo_data_ready, fifo_all_done;
  logic         pipe_dir_out, packet_count_done, short_packet_done, buffer_full_done, req_pol;
  logic         split_data_pins_oe, dma_request_o, dma_request_oe, dma_transfer_end_o, ack_pol;
  logic         dma_transfer_end_oe, dma_xfer_pulse, cpu_fifo_wr, cpu_fifo_rd;
  logic [3:0]   wait_cyc;
  logic [7:0]   reg_addr, split_data_pins_i, split_data_pins_o, fifo_tx_byte, dma_rx_byte;
  logic [15:0]  reg_wdata, reg_rdata, fifo_cpu_rd_data, cpu_fifo_wdata;
  dpc_hs_pins_t hs_pins_i;
  int           n_mismatch, comparisons, cycles, k, xfers;
  ////////////////////////////////////////////////////////////
  dpc_top dpc_top_inst (
    .mclk                (mclk),
    .rst_n               (rst_n),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .split_data_pins_i   (split_data_pins_i),
    .split_data_pins_o   (split_data_pins_o),
    .split_data_pins_oe  (split_data_pins_oe),
    .hs_pins_i           (hs_pins_i),
    .cpu_dma_select      (cpu_dma_select),
    .dma_request_o       (dma_request_o),
    .dma_request_oe      (dma_request_oe),
    .dma_transfer_end_o  (dma_transfer_end_o),
    .dma_transfer_end_oe (dma_transfer_end_oe),
    .fifo_data_ready     (fifo_data_ready),
    .fifo_all_done       (fifo_all_done),
    .pipe_dir_out        (pipe_dir_out),
    .packet_count_done   (packet_count_done),
    .short_packet_done   (short_packet_done),
    .buffer_full_done    (buffer_full_done),
    .fifo_tx_byte        (fifo_tx_byte),
    .dma_xfer_pulse      (dma_xfer_pulse),
    .dma_rx_byte         (dma_rx_byte),
    .fifo_cpu_rd_data    (fifo_cpu_rd_data),
    .cpu_fifo_wr         (cpu_fifo_wr),
    .cpu_fifo_rd         (cpu_fifo_rd),
    .cpu_fifo_wdata      (cpu_fifo_wdata)
  );
  dpc_dma_model dpc_dma_model_inst (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .req      (dma_request_oe ? dma_request_o : !req_pol), // Undriven pin rests idle
    .req_pol  (req_pol),
    .ack_pol  (ack_pol),
    .wait_cyc (wait_cyc),
    .hs_pins  (hs_pins_i)
  );
  always #5 mclk = !mclk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Bus cycles start on an edge, so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    chk(name, exp, reg_rdata);
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog against a stuck handshake
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'h0;
    rst_n = 1'h0;
    {reg_wr, reg_rd, cpu_dma_select, fifo_data_ready, fifo_all_done, req_pol, ack_pol} = '0;
    {pipe_dir_out, packet_count_done, short_packet_done, buffer_full_done} = '0;
    {reg_addr, reg_wdata, fifo_tx_byte, wait_cyc} = '0;
    split_data_pins_i = 8'hA5;
    fifo_cpu_rd_data = 16'hABCD;
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    rd(DPC_MODE_OFS, 16'h0000, "mode reset");
    rd(DPC_HS_OFS, 16'h0000, "hs reset");
    rd(8'h02, 16'h0000, "unmapped");
    wr(DPC_MODE_OFS, 16'hFFFF);
    rd(DPC_MODE_OFS, 16'h0105, "mode reserved");
    wr(DPC_HS_OFS, 16'hFFFF);
    rd(DPC_HS_OFS, 16'h7774, "hs reserved");
    wr(DPC_HS_OFS, 16'h0000);
    wr(DPC_MODE_OFS, 16'h0000);
    wr(DPC_PORTA_OFS, 16'h003C);
    rd(DPC_PORTA_OFS, 16'h00A5, "port input");
    chk("port oe", 16'h0000, {15'h0, split_data_pins_oe});
    wr(DPC_MODE_OFS, 16'h0004);
    repeat (2) @(posedge mclk);
    #1 chk("port out", 16'h013C, {7'h0, split_data_pins_oe, split_data_pins_o});
    // Byte order both ways on the FIFO port
    for (k = 0; k < 2; k++) begin
      wr(DPC_MODE_OFS, k[0] ? 16'h0100 : 16'h0000);
      wr(DPC_FIFO_OFS, 16'h1234);
      chk("fifo wr", k[0] ? 16'h3412 : 16'h1234, cpu_fifo_wdata);
      rd(DPC_FIFO_OFS, k[0] ? 16'hCDAB : 16'hABCD, "fifo rd");
      chk("fifo rd pulse", 16'h0001, {15'h0, cpu_fifo_rd});
    end
    wr(DPC_MODE_OFS, 16'h0001);
    wr(DPC_FIFO_OFS, 16'h1234);
    chk("fifo wr ignored", 16'h0000, {15'h0, cpu_fifo_wr});
    rd(DPC_FIFO_OFS, 16'h0000, "fifo rd ignored");
    chk("fifo rd pulse ignored", 16'h0000, {15'h0, cpu_fifo_rd});
    // Cycle-steal with prompt partner, burst with slow partner, both polarities each
    for (k = 0; k < 4; k++) begin
      req_pol <= k[1];
      ack_pol <= k[1];
      wait_cyc <= k[0] ? 4'h6 : 4'h1;
      wr(DPC_HS_OFS, 16'h1300 | (k[1] ? 16'h4400 : 16'h0000) | (k[0] ? 16'h2000 : 16'h0000));
      fifo_data_ready <= 1'h1;
      xfers = 0;
      repeat (40) begin
        @(posedge mclk);
        #1;
        if (dma_xfer_pulse === 1'h1) xfers++;
      end
      chk("transfers", 16'h0003, {14'h0, xfers > 0, dma_request_oe});
      chk("rx byte", 16'h00A5, {8'h00, dma_rx_byte});
      fifo_data_ready <= 1'h0;
      fifo_all_done <= 1'h1;
      repeat (16) @(posedge mclk);
      #1 chk("request idle", {15'h0, !k[1]}, {15'h0, dma_request_o});
      fifo_all_done <= 1'h0;
    end
    // End pin in both modes and polarities, OUT pipe
    pipe_dir_out <= 1'h1;
    packet_count_done <= 1'h1;
    for (k = 0; k < 4; k++) begin
      wr(DPC_HS_OFS, 16'h0110 | (k[0] ? 16'h0040 : 16'h0000) | (k[1] ? 16'h0020 : 16'h0000));
      repeat (3) @(posedge mclk);
      #1 chk("end level", {15'h0, k[0] ^ k[1]}, {15'h0, dma_transfer_end_o});
      chk("fast drive", 16'h0003, {14'h0, dma_transfer_end_oe, split_data_pins_oe});
    end
    wr(DPC_HS_OFS, 16'h0114);
    repeat (3) @(posedge mclk);
    #1 chk("normal drive", 16'h0000, {14'h0, dma_transfer_end_oe, split_data_pins_oe});
    final_report;
  end
endmodule
